// [icbb_pkg.sv]
package icbb_pkg;

  // Register word offsets on the plain register port
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_WIDTH  = 8'h04;
  localparam logic [7:0] REG_MBASE  = 8'h08;
  localparam logic [7:0] REG_MMASK  = 8'h0c;
  localparam logic [7:0] REG_DBASE  = 8'h10;
  localparam logic [7:0] REG_DMASK  = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // Control field positions
  localparam int CTRL_SLOW_BIT = 0;
  localparam int CTRL_RR_BIT   = 1;

  // Reset values
  localparam logic [1:0]  CTRL_RST  = 2'h0;
  localparam logic [23:0] WIDTH_RST = 24'h000000;
  localparam logic [31:0] MBASE_RST = 32'h1c000000;
  localparam logic [31:0] MMASK_RST = 32'hfc000000;
  localparam logic [31:0] DBASE_RST = 32'h00000000;
  localparam logic [31:0] DMASK_RST = 32'hf0000000;

  // Fixed decode spaces, compared on address bits 31:24; PCI on bits 31:28
  localparam logic [7:0] CTRL_SPACE = 8'h18;
  localparam logic [7:0] PERI_SPACE = 8'h19;
  localparam logic [3:0] PCI_SPACE  = 4'h4;

  // Chip select positions
  localparam int SEL_DRAM = 0;
  localparam int SEL_MEM  = 1;
  localparam int SEL_PCI  = 2;
  localparam int SEL_PERI = 3;
  localparam int SEL_CTRL = 4;

  // Region numbers A..L
  localparam logic [3:0] RGN_E = 4'h4;
  localparam logic [3:0] RGN_G = 4'h6;
  localparam logic [3:0] RGN_H = 4'h7;
  localparam logic [3:0] RGN_I = 4'h8;
  localparam logic [3:0] RGN_J = 4'h9;
  localparam logic [3:0] RGN_K = 4'ha;
  localparam logic [3:0] RGN_L = 4'hb;

  // Width codes
  localparam logic [1:0] W_8  = 2'h0;
  localparam logic [1:0] W_16 = 2'h1;
  localparam logic [1:0] W_32 = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEC2, ST_ROW, ST_DATA, ST_NEXT
  } icbb_state_e;

  // Masked compare: a cleared mask bit drops out of the match
  function automatic logic icbb_hit(input logic [31:0] a,
                                    input logic [31:0] b,
                                    input logic [31:0] m);
    return ((a ^ b) & m) == 32'h0;
  endfunction : icbb_hit

  // Bytes per beat for a width code; reserved falls back to a word
  function automatic logic [2:0] icbb_bytes(input logic [1:0] w);
    case (w)
      W_8:     return 3'h1;
      W_16:    return 3'h2;
      default: return 3'h4;
    endcase
  endfunction : icbb_bytes

endpackage : icbb_pkg

// [icbb_arbiter.sv]
`timescale 1ns/1ps
module icbb_arbiter
  import icbb_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       cpu_req,
  input  wire logic [4:0] ext_req,
  input  wire logic       rr_mode,
  input  wire logic       take,
  output logic            cpu_win,
  output logic [4:0]      ext_win
);

  logic [2:0] ptr_reg;
  logic       last_ext_reg;

  // First requester at or after the pointer, wrapping over five slots
  function automatic logic [4:0] icbb_pick(input logic [4:0] r,
                                           input logic [2:0] p);
    logic [4:0] g;
    logic [2:0] k;
    logic [3:0] s;
    g = 5'h0;
    for (int i = 4; i >= 0; i--) begin
      // Sum kept one bit wider so slot 4 plus 4 does not wrap early
      s = {1'b0, p} + 4'(i);
      k = (s > 4'd4) ? 3'(s - 4'd5) : s[2:0];
      if (r[k]) begin
        g = 5'h0;
        g[k] = 1'b1;
      end
    end
    return g;
  endfunction : icbb_pick

  // CPU ranks first but yields once after it held the bus, and out of reset
  always_comb begin
    cpu_win = cpu_req & ((ext_req == 5'h0) | last_ext_reg);
    ext_win = cpu_win ? 5'h0 : icbb_pick(ext_req, rr_mode ? ptr_reg : 3'h0);
  end

  // Rotate the channel order by one after each peripheral grant
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ptr_reg      <= 3'h0;
      last_ext_reg <= 1'b0;
    end else if (take) begin
      last_ext_reg <= ext_win != 5'h0;
      if (rr_mode && ext_win != 5'h0)
        ptr_reg <= (ptr_reg == 3'd4) ? 3'h0 : ptr_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_rr_rotate: assert property (take && rr_mode && ext_win != 5'h0 |=>
    ptr_reg == (($past(ptr_reg) == 3'd4) ? 3'h0 : $past(ptr_reg) + 3'h1))
    else $error("round robin pointer did not rotate");

  a_fixed_order: assert property (!rr_mode && !cpu_win && ext_req[0]
    |-> ext_win == 5'h1)
    else $error("fixed order did not favour channel zero");

endmodule : icbb_arbiter

// [icbb_bridge.sv]
`timescale 1ns/1ps
module icbb_bridge
  import icbb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        cpu_req,
  input  wire logic [31:0] cpu_addr,
  input  wire logic        cpu_write,
  input  wire logic [1:0]  cpu_len,
  input  wire logic [31:0] cpu_wdata,
  output logic [31:0]      cpu_ad_o,
  output logic             cpu_ad_oe,
  output logic             busgnt_n,
  input  wire logic [4:0]  dma_req,
  input  wire logic [31:0] dma_addr,
  input  wire logic        dma_write,
  input  wire logic [1:0]  dma_len,
  input  wire logic [31:0] dma_wdata,
  output logic [4:0]       dma_gnt,
  output logic             xfer_wnext,
  output logic             xfer_rvalid,
  output logic             xfer_done,
  output logic [25:2]      mem_addr,
  output logic             mem_sdram_row,
  output logic             mem_strobe,
  output logic             mem_we,
  output logic [31:0]      mem_data_o,
  output logic             mem_data_oe,
  input  wire logic [31:0] mem_data_i,
  input  wire logic        mem_ack,
  output logic [4:0]       chip_sel,
  output logic [3:0]       mem_region,
  output logic [2:0]       mem_port_bytes
);

  icbb_state_e state_reg;
  logic [1:0]  ctrl_reg;
  logic [23:0] width_reg;
  logic [31:0] mbase_reg;
  logic [31:0] mmask_reg;
  logic [31:0] dbase_reg;
  logic [31:0] dmask_reg;
  logic [31:0] addr_reg;
  logic [31:0] start_reg;
  logic [31:0] data_reg;
  logic [1:0]  cnt_reg;
  logic [1:0]  len_reg;
  logic        write_reg;
  logic        cpu_own_reg;
  logic [4:0]  gnt_reg;
  logic        rvalid_reg;
  logic        done_reg;
  logic [4:0]  sel_next;
  logic [3:0]  region_next;
  logic [31:0] src_addr;
  logic [31:0] src_wdata;
  logic        src_write;
  logic [1:0]  src_len;
  logic        cpu_win;
  logic [4:0]  ext_win;
  logic        take;
  logic        subblk;
  logic        last_word;
  logic [1:0]  cnt_inc;

  // Any request starts a transaction in idle; the arbiter picks the winner
  assign take = (state_reg == ST_IDLE) && (cpu_req || dma_req != 5'h0);

  icbb_arbiter u_arb (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .cpu_req (cpu_req),
    .ext_req (dma_req),
    .rr_mode (ctrl_reg[CTRL_RR_BIT]),
    .take    (take),
    .cpu_win (cpu_win),
    .ext_win (ext_win)
  );

  // Address, direction and length come from this cycle's winner; write data from the latched owner
  always_comb begin
    src_addr  = cpu_win ? cpu_addr  : dma_addr;
    src_write = cpu_win ? cpu_write : dma_write;
    src_len   = cpu_win ? cpu_len   : dma_len;
    src_wdata = cpu_own_reg ? cpu_wdata : dma_wdata;
  end

  // Space compare in the accept clock; masked for SDRAM and memory
  always_comb begin
    sel_next    = 5'h0;
    region_next = RGN_L;
    if (icbb_hit(src_addr, dbase_reg, dmask_reg)) begin
      sel_next[SEL_DRAM] = 1'b1;
      region_next = {2'h0, src_addr[27:26]};
    end else if (icbb_hit(src_addr, mbase_reg, mmask_reg)) begin
      sel_next[SEL_MEM] = 1'b1;
      region_next = src_addr[25] ? RGN_I : RGN_H;
    end else if (src_addr[31:28] == PCI_SPACE) begin
      sel_next[SEL_PCI] = 1'b1;
      region_next = src_addr[27] ? RGN_K : RGN_J;
    end else if (src_addr[31:24] == CTRL_SPACE) begin
      sel_next[SEL_CTRL] = 1'b1;
      region_next = RGN_G;
    end else if (src_addr[31:24] == PERI_SPACE) begin
      sel_next[SEL_PERI] = 1'b1;
      region_next = RGN_E;
    end
  end

  // Burst ordering: only CPU reads use subblock order
  assign subblk    = cpu_own_reg && !write_reg;
  assign last_word = cnt_reg == len_reg;
  assign cnt_inc   = cnt_reg + 2'h1;

  // Register writes; the decode setting is meant to be fixed at boot
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg  <= CTRL_RST;
      width_reg <= WIDTH_RST;
      mbase_reg <= MBASE_RST;
      mmask_reg <= MMASK_RST;
      dbase_reg <= DBASE_RST;
      dmask_reg <= DMASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL)
        ctrl_reg <= reg_wdata[1:0];
      else if (reg_addr == REG_WIDTH)
        width_reg <= reg_wdata[23:0];
      else if (reg_addr == REG_MBASE)
        mbase_reg <= reg_wdata;
      else if (reg_addr == REG_MMASK)
        mmask_reg <= reg_wdata;
      else if (reg_addr == REG_DBASE)
        dbase_reg <= reg_wdata;
      else if (reg_addr == REG_DMASK)
        dmask_reg <= reg_wdata;
    end
  end

  // Read data lands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      if (reg_addr == REG_CTRL)
        reg_rdata <= {30'h0, ctrl_reg};
      else if (reg_addr == REG_WIDTH)
        reg_rdata <= {8'h0, width_reg};
      else if (reg_addr == REG_MBASE)
        reg_rdata <= mbase_reg;
      else if (reg_addr == REG_MMASK)
        reg_rdata <= mmask_reg;
      else if (reg_addr == REG_DBASE)
        reg_rdata <= dbase_reg;
      else if (reg_addr == REG_DMASK)
        reg_rdata <= dmask_reg;
      else if (reg_addr == REG_STATUS)
        reg_rdata <= {24'h0, 1'b0, state_reg != ST_IDLE, cpu_own_reg,
                      gnt_reg};
      else
        reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // Transaction sequencing
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            if (ctrl_reg[CTRL_SLOW_BIT])
              state_reg <= ST_DEC2;
            else if (sel_next[SEL_DRAM])
              state_reg <= ST_ROW;
            else
              state_reg <= ST_DATA;
          end
        end
        ST_DEC2: begin
          state_reg <= chip_sel[SEL_DRAM] ? ST_ROW : ST_DATA;
        end
        ST_ROW: begin
          state_reg <= ST_DATA;
        end
        ST_DATA: begin
          if (mem_ack)
            state_reg <= last_word ? ST_IDLE : ST_NEXT;
        end
        ST_NEXT: begin
          state_reg <= ST_DATA;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Ownership is latched at accept and dropped back to the CPU after
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpu_own_reg <= 1'b1;
      gnt_reg     <= 5'h0;
    end else if (take) begin
      cpu_own_reg <= cpu_win;
      gnt_reg     <= ext_win;
    end else if (state_reg == ST_DATA && mem_ack && last_word) begin
      cpu_own_reg <= 1'b1;
      gnt_reg     <= 5'h0;
    end
  end

  // Selects, region and width are held for the whole transaction
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      chip_sel       <= 5'h0;
      mem_region     <= RGN_L;
      mem_port_bytes <= 3'h4;
    end else if (take) begin
      chip_sel   <= sel_next;
      mem_region <= region_next;
      if (region_next == RGN_H || region_next == RGN_I)
        mem_port_bytes <= icbb_bytes(width_reg[2*region_next +: 2]);
      else
        mem_port_bytes <= icbb_bytes(W_32);
    end else if (state_reg == ST_DATA && mem_ack && last_word) begin
      chip_sel <= 5'h0;
    end
  end

  // Burst address and word count
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addr_reg  <= 32'h0;
      start_reg <= 32'h0;
      cnt_reg   <= 2'h0;
      len_reg   <= 2'h0;
      write_reg <= 1'b0;
    end else if (take) begin
      addr_reg  <= {src_addr[31:2], 2'h0};
      start_reg <= {src_addr[31:2], 2'h0};
      cnt_reg   <= 2'h0;
      len_reg   <= src_len;
      write_reg <= src_write;
    end else if (state_reg == ST_DATA && mem_ack && !last_word) begin
      cnt_reg <= cnt_inc;
      if (subblk)
        addr_reg <= {addr_reg[31:4], start_reg[3:2] ^ cnt_inc, 2'h0};
      else
        addr_reg <= addr_reg + 32'h4;
    end
  end

  // Data path: write words loaded ahead of the strobe, read words caught
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      data_reg <= 32'h0;
    end else if (take && src_write) begin
      data_reg <= cpu_win ? cpu_wdata : dma_wdata;
    end else if (state_reg == ST_NEXT && write_reg) begin
      data_reg <= src_wdata;
    end else if (state_reg == ST_DATA && mem_ack && !write_reg) begin
      data_reg <= mem_data_i;
    end
  end

  // One-cycle answers back to the requester
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      rvalid_reg <= state_reg == ST_DATA && mem_ack && !write_reg;
      done_reg   <= state_reg == ST_DATA && mem_ack && last_word;
    end
  end

  assign xfer_rvalid = rvalid_reg;
  assign xfer_done   = done_reg;
  assign xfer_wnext  = state_reg == ST_DATA && mem_ack && write_reg;
  assign dma_gnt     = gnt_reg;
  // Low while the CPU holds the bus; high tells it another master won
  assign busgnt_n    = !cpu_own_reg;

  // Memory side strobes and data
  assign mem_strobe    = state_reg == ST_DATA;
  assign mem_we        = write_reg && state_reg == ST_DATA;
  assign mem_data_o    = data_reg;
  assign mem_data_oe   = write_reg && state_reg == ST_DATA;
  assign mem_sdram_row = state_reg == ST_ROW;

  // Internal bus: write data in a CPU write, read data back, any DMA
  assign cpu_ad_o  = data_reg;
  assign cpu_ad_oe = (state_reg == ST_DATA && write_reg) || rvalid_reg
                     || !cpu_own_reg;

  // Address mux; SDRAM splits the word into row and column phases
  always_comb begin
    mem_addr = addr_reg[25:2];
    if (chip_sel[SEL_DRAM]) begin
      mem_addr = 24'h0;
      if (state_reg == ST_ROW)
        mem_addr[15:2] = addr_reg[29:16];
      else
        mem_addr[15:2] = addr_reg[15:2];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_row_phase;
    mem_sdram_row && mem_addr[15:2] == addr_reg[29:16];
  endsequence

  sequence s_col_phase;
    state_reg == ST_DATA && !mem_sdram_row
      && mem_addr[15:2] == addr_reg[15:2];
  endsequence

  a_burst_step: assert property (state_reg == ST_DATA && mem_ack
    && !last_word |=> addr_reg != $past(addr_reg) ##1 mem_strobe)
    else $error("burst address did not advance");

  a_subblock_order: assert property (mem_strobe && subblk |->
    addr_reg[3:2] == (start_reg[3:2] ^ cnt_reg))
    else $error("CPU read not in subblock order");

  a_linear_order: assert property (mem_strobe && !subblk |->
    addr_reg == start_reg + {28'h0, cnt_reg, 2'h0})
    else $error("linear burst address wrong");

  a_mux_rom: assert property (mem_strobe && !chip_sel[SEL_DRAM]
    |-> mem_addr == addr_reg[25:2])
    else $error("memory address lines wrong");

  a_sdram_phases: assert property (state_reg == ST_ROW |->
    s_row_phase ##1 s_col_phase)
    else $error("SDRAM row then column not presented");

  a_decode_slow: assert property (take && ctrl_reg[CTRL_SLOW_BIT]
    |=> state_reg == ST_DEC2 ##1 state_reg != ST_DEC2)
    else $error("slow decode not two clocks");

  a_decode_fast: assert property (take && !ctrl_reg[CTRL_SLOW_BIT]
    |=> state_reg == ST_ROW || state_reg == ST_DATA)
    else $error("fast decode not one clock");

  a_select_hold: assert property (take |=> $onehot0(chip_sel)
    && chip_sel == $past(sel_next))
    else $error("chip select not from decode");

  a_cpu_write_bus: assert property (mem_strobe && write_reg
    && cpu_own_reg |-> cpu_ad_oe && cpu_ad_o == mem_data_o)
    else $error("CPU write data not on internal bus");

  a_read_return: assert property (mem_strobe && mem_ack
    && !write_reg |=> xfer_rvalid && data_reg == $past(mem_data_i))
    else $error("read data not returned");

  a_dma_write: assert property (mem_strobe && write_reg
    && !cpu_own_reg |-> mem_data_oe && mem_we)
    else $error("peripheral write data not driven");

  a_default_cpu: assert property (state_reg == ST_IDLE
    |-> !busgnt_n && gnt_reg == 5'h0)
    else $error("CPU not default owner");

  a_width_fixed: assert property (mem_strobe && mem_region != RGN_H
    && mem_region != RGN_I |-> mem_port_bytes == 3'h4)
    else $error("fixed region not word wide");

  a_one_owner: assert property ($onehot({cpu_own_reg, gnt_reg}))
    else $error("bus ownership broken");

  a_owner_hold: assert property (state_reg != ST_IDLE |=>
    $stable(gnt_reg) || state_reg == ST_IDLE)
    else $error("bus owner changed inside a transaction");

endmodule : icbb_bridge

// [icbb_mem_model.sv]
`timescale 1ns/1ps
// Memory side: acks each strobed word after mem_dly + 1 strobed cycles without ack
module icbb_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        mem_strobe,
  input  wire logic [25:2] mem_addr,
  input  wire logic [1:0]  mem_dly,
  output logic             mem_ack,
  output logic [31:0]      mem_data_i
);
  logic [1:0] wait_reg;

  initial begin
    mem_ack = 1'b0;
    mem_data_i = 32'h0;
    wait_reg = 2'h0;
  end

  // Idle data lines toggle so a stale word never passes for a fresh one
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_data_i <= ~mem_data_i;
    if (mem_strobe && !mem_ack) begin
      if (wait_reg == mem_dly) begin
        mem_ack    <= 1'b1;
        mem_data_i <= {8'h5a, 10'h000, mem_addr[15:2]};
        wait_reg   <= 2'h0;
      end else begin
        wait_reg <= wait_reg + 2'h1;
      end
    end
  end
endmodule : icbb_mem_model

// [test_icbb_bridge.sv]
`timescale 1ns/1ps
module test_icbb_bridge;
  import icbb_pkg::*;
  logic        clk_sys, resetn, reg_wr, reg_rd, cpu_req, cpu_write;
  logic        dma_write, cpu_ad_oe, busgnt_n, xfer_wnext, xfer_rvalid;
  logic        xfer_done, mem_sdram_row, mem_strobe, mem_we, mem_data_oe;
  logic        mem_ack, wn, o_bg, o_oe;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cpu_addr, cpu_wdata, dma_addr;
  logic [31:0] dma_wdata, cpu_ad_o, mem_data_o, mem_data_i;
  logic [1:0]  cpu_len, dma_len, mem_dly;
  logic [4:0]  dma_req, dma_gnt, chip_sel, o_sel, o_gnt;
  logic [25:2] mem_addr;
  logic [3:0]  mem_region, o_rgn;
  logic [2:0]  mem_port_bytes, o_pb;
  logic [31:0] qa[$], qd[$], qr[$];
  int          n_mismatch = 0, checks = 0, lat, rows;

  icbb_bridge DUT (.*);
  icbb_mem_model MEM (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Collect word traffic mid-cycle, once outputs have settled
  always @(negedge clk_sys) begin
    wn <= xfer_wnext;
    if (mem_strobe && mem_ack) qa.push_back({8'h0, mem_addr});
    if (mem_strobe && mem_ack && mem_we) qd.push_back(mem_data_o);
    if (xfer_rvalid) qr.push_back(cpu_ad_o);
    if (mem_sdram_row) rows++;
  end

  // Next write word is presented right after the previous one is taken
  always @(posedge clk_sys) if (wn) begin
    cpu_wdata <= cpu_wdata + 32'h01010101;
    dma_wdata <= dma_wdata + 32'h01010101;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  // One transaction; the winner's request drops once ownership shows, lat counts to strobe
  task automatic xact(input logic c, input logic [4:0] d,
                      input logic [31:0] a, input logic w,
                      input logic [1:0] l);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    lat = 0;
    rows = 0;
    qa.delete();
    qd.delete();
    qr.delete();
    @(posedge clk_sys);
    cpu_req <= c;
    dma_req <= d;
    cpu_addr <= a;
    dma_addr <= a;
    cpu_write <= w;
    dma_write <= w;
    cpu_len <= l;
    dma_len <= l;
    cpu_wdata <= 32'h11223344;
    dma_wdata <= 32'hc0de0001;
    while (n < 80) begin
      @(negedge clk_sys);
      n++;
      if (lat == 0 && mem_strobe) lat = n;
      if (!got && chip_sel != 5'h0) begin
        got = 1'b1;
        {o_sel, o_gnt, o_bg, o_oe} = {chip_sel, dma_gnt, busgnt_n, cpu_ad_oe};
        {o_rgn, o_pb} = {mem_region, mem_port_bytes};
        @(posedge clk_sys);
        if (busgnt_n) dma_req <= 5'h0;
        else cpu_req <= 1'b0;
      end
      if (xfer_done) break;
    end
    // Let the word collector take the last read word before anyone looks
    @(posedge clk_sys);
    if (n >= 80) chk("xfer_done", 32'h1, 32'h0);
  endtask : xact

  task automatic t_regs;
    logic [7:0]  ra[8];
    logic [31:0] rv[8];
    logic [31:0] d;
    ra = '{REG_CTRL, REG_WIDTH, REG_MBASE, REG_MMASK, REG_DBASE, REG_DMASK,
           REG_STATUS, 8'h1c};
    rv = '{32'h0, 32'h0, MBASE_RST, MMASK_RST, DBASE_RST, DMASK_RST, 32'h20,
           32'h0};
    wr(REG_STATUS, 32'hffffffff);
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], d);
      chk("register", rv[i], d);
    end
  endtask : t_regs

  task automatic t_cpu_write;
    xact(1'b1, 5'h0, 32'h1c000008, 1'b1, 2'h1);
    chk("latency", 2, lat);
    chk("chip_sel", 32'h1 << SEL_MEM, o_sel);
    chk("region", RGN_H, o_rgn);
    chk("port_bytes", 1, o_pb);
    chk("cpu_ad_oe", 1, o_oe);
    chk("addr0", 2, qa[0]);
    chk("addr1", 3, qa[1]);
    chk("wdata0", 32'h11223344, qd[0]);
    chk("wdata1", 32'h12233445, qd[1]);
  endtask : t_cpu_write

  task automatic t_slow;
    logic [31:0] d;
    wr(REG_CTRL, 32'h1);
    wr(REG_WIDTH, 32'h00004000);
    rd(REG_WIDTH, d);
    chk("width", 32'h4000, d);
    xact(1'b1, 5'h0, 32'h1c000010, 1'b1, 2'h0);
    chk("slow_latency", 3, lat);
    chk("port_bytes", 2, o_pb);
    chk("addr0", 4, qa[0]);
    wr(REG_CTRL, 32'h0);
  endtask : t_slow

  // Slow device, wrap from word 2: order 2,3,0,1
  task automatic t_sdram_read;
    logic [31:0] c[4];
    c = '{32'h6, 32'h7, 32'h4, 32'h5};
    mem_dly = 2'h2;
    xact(1'b1, 5'h0, 32'h00000018, 1'b0, 2'h3);
    mem_dly = 2'h0;
    chk("row_phase", 1, rows != 0);
    chk("chip_sel", 32'h1 << SEL_DRAM, o_sel);
    chk("port_bytes", 4, o_pb);
    for (int i = 0; i < 4; i++) begin
      chk("column", c[i], qa[i] & 32'h3fff);
      chk("rdata", 32'h5a000000 | c[i], qr[i]);
    end
  endtask : t_sdram_read

  task automatic t_dma;
    xact(1'b0, 5'h02, 32'h0000001c, 1'b1, 2'h1);
    chk("dma_gnt", 2, o_gnt);
    chk("busgnt_n", 1, o_bg);
    chk("addr0", 7, qa[0] & 32'h3fff);
    chk("addr1", 8, qa[1] & 32'h3fff);
    chk("wdata0", 32'hc0de0001, qd[0]);
    chk("wdata1", 32'hc1df0102, qd[1]);
    xact(1'b0, 5'h02, 32'h1e00000c, 1'b0, 2'h1);
    chk("port_bytes", 1, o_pb);
    chk("addr1", 32'h800004, qa[1]);
    chk("rdata0", 32'h5a000003, qr[0]);
    chk("rdata1", 32'h5a000004, qr[1]);
  endtask : t_dma

  task automatic t_arb;
    logic [4:0] p;
    xact(1'b0, 5'h1f, 32'h1c, 1'b0, 2'h0);
    chk("fixed_gnt", 1, o_gnt);
    xact(1'b0, 5'h1e, 32'h1c, 1'b0, 2'h0);
    chk("fixed_gnt", 2, o_gnt);
    wr(REG_CTRL, 32'h2);
    xact(1'b0, 5'h1f, 32'h1c, 1'b0, 2'h0);
    p = o_gnt;
    repeat (5) begin
      xact(1'b0, 5'h1f, 32'h1c, 1'b0, 2'h0);
      chk("rr_gnt", {p[3:0], p[4]}, o_gnt);
      p = o_gnt;
    end
    xact(1'b1, 5'h04, 32'h1c, 1'b0, 2'h0);
    chk("cpu_first", 0, o_bg);
    chk("one_owner", 0, o_gnt);
    xact(1'b0, 5'h04, 32'h1c, 1'b0, 2'h0);
    chk("dma_next", 4, o_gnt);
    @(negedge clk_sys);
    chk("busgnt_n", 0, busgnt_n);
  endtask : t_arb

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #50000;
    n_mismatch++;
    summarize();
  end

  initial begin
    {resetn, reg_wr, reg_rd, cpu_req, cpu_write, dma_write} = 6'h0;
    {reg_addr, reg_wdata, cpu_addr, cpu_wdata, dma_addr, dma_wdata} = '0;
    {cpu_len, dma_len, mem_dly, dma_req} = '0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    chk("busgnt_n", 0, busgnt_n);
    chk("chip_sel", 0, chip_sel);
    chk("port_bytes", 4, mem_port_bytes);
    t_regs();
    t_cpu_write();
    t_slow();
    t_sdram_read();
    t_dma();
    t_arb();
    summarize();
  end
endmodule : test_icbb_bridge
